// ### rtl/acc_top.sv
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module acc_top
  import acc_pkg::*;
#(
  parameter int NCH = 2, // amplifier channels
  parameter int CNT_W = 8 // sync period counter width
)(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [3:0] s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  input wire logic adc_clk_tick, // one pulse per adc clock
  input wire logic t0_cmp, // timer 0 compare pulse
  input wire logic t0_ovf, // timer 0 overflow pulse
  input wire logic t1_cmpb, // timer 1 compare b pulse
  input wire logic t1_ovf, // timer 1 overflow pulse
  input wire logic power_stage_sync_zero, // stage sync 0 pulse
  input wire logic power_stage_sync_one, // stage sync 1 pulse
  input wire logic power_stage_sync_two, // stage sync 2 pulse
  input wire logic [NCH-1:0] conv_req, // conversion request per channel
  input wire logic [NCH-1:0] conv_busy, // conversion running per channel
  output logic [NCH-1:0] amp_on, // amplifier effectively on
  output logic [NCH-1:0] in_short, // inputs shorted
  output logic [2*NCH-1:0] gain_code, // gain field per channel
  output logic [6*NCH-1:0] gain_val, // gain figure per channel
  output logic [NCH-1:0] cmp_link, // output fed to comparator
  output logic [NCH-1:0] amp_clk, // amplification pulse
  output logic [NCH-1:0] cmp_clk, // comparator clock pulse
  output logic [NCH-1:0] conv_go // conversion start pulse
);
  logic [7:0] ctrl_r [NCH]; // control registers
  logic [7:0] ctrl_nxt [NCH];
  logic [2:0] div_r, div_nxt; // adc clock divider
  logic div_ev_r, div_ev_nxt; // adc clock / 8 event
  logic [7:0] evt; // sync event vector
  // bus state
  logic aw_full_r, aw_full_nxt; // address latched
  logic w_full_r, w_full_nxt; // data latched
  logic [3:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_data_r, w_data_nxt; // low byte is all we keep
  logic w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic do_wr; // both halves of a write present

  assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
  assign evt = {power_stage_sync_two, power_stage_sync_one, power_stage_sync_zero,
    t1_ovf, t1_cmpb, t0_ovf, t0_cmp, div_ev_r}; // see R7

  // adc clock divide by 8 and register file next state
  always_comb
  begin
    div_nxt = adc_clk_tick ? div_r + 3'h1 : div_r;
    div_ev_nxt = adc_clk_tick && div_r == ACC_ADC_DIV_LAST;
    for (int i = 0; i < NCH; i++)
    begin
      ctrl_nxt[i] = ctrl_r[i];
      // byte lane 0 holds the whole register
      if (do_wr && w_strb_r && aw_addr_r == 4'(i * 4))
        ctrl_nxt[i] = w_data_r; // see R11
    end
  end

  // bus next state; address and data taken in either order
  always_comb
  begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_strb_nxt = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      // unmapped address answers with an error and writes nothing
      bresp_nxt = (aw_addr_r == ACC_OFS_AMP_ONE || aw_addr_r == ACC_OFS_AMP_TWO) ?
        ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = ACC_RESP_OKAY;
      // upper bits read as zero
      if (s_axi_araddr == ACC_OFS_AMP_ONE)
        rdata_nxt = {24'h000000, ctrl_r[0]}; // see R11
      else if (s_axi_araddr == ACC_OFS_AMP_TWO)
        rdata_nxt = {24'h000000, ctrl_r[1]}; // see R9
      else
      begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = ACC_RESP_SLVERR;
      end
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    // ready only while the slot is empty, dropped the cycle it fills
    awready_nxt = ~aw_full_nxt;
    wready_nxt = ~w_full_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NCH; i++)
        ctrl_r[i] <= ACC_CTRL_RESET; // see R11
      div_r <= 3'h0;
      div_ev_r <= 1'b0;
      aw_full_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_full_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= ACC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= ACC_RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      div_ev_r <= div_ev_nxt;
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r <= w_full_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // one identical, independent channel per control register
  for (genvar g = 0; g < NCH; g++)
  begin : gen_ch
    acc_chan_if chi ();
    assign chi.cfg = ctrl_r[g]; // see R9
    assign chi.evt = evt;
    assign chi.conv_req = conv_req[g];
    assign chi.conv_busy = conv_busy[g];
    acc_chan #(.CNT_W(CNT_W)) u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .ch(chi)
    );
    assign amp_on[g] = chi.amp_on;
    assign in_short[g] = chi.in_short;
    assign gain_code[2*g +: 2] = chi.gain_code;
    assign gain_val[6*g +: 6] = chi.gain_val;
    assign cmp_link[g] = chi.cmp_link;
    assign amp_clk[g] = chi.amp_clk;
    assign cmp_clk[g] = chi.cmp_clk;
    assign conv_go[g] = chi.conv_go;
  end

  chk_reg_write: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
    ce && do_wr && w_strb_r && aw_addr_r == ACC_OFS_AMP_TWO |=> ctrl_r[1] == $past(w_data_r))
    else $error("register write lost");
  chk_reset_zero: assert property (@(posedge aclk) // see R11
    $past(!aresetn) |-> ctrl_r[0] == ACC_CTRL_RESET && ctrl_r[1] == ACC_CTRL_RESET)
    else $error("register not zero after reset");
  chk_div_eight: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
    div_ev_r && $past(ce) |-> $past(div_r) == ACC_ADC_DIV_LAST) else $error("adc divide wrong");
endmodule
`default_nettype wire

// ### rtl/acc_pkg.sv
// Overview of operation
// R1 - enable on at once, off after running conversion
// R2 - software clears clock select when clearing enable
// R3 - shunt bit shorts the amplifier inputs
// R4 - gain field 00/01/10/11 gives 5/10/20/40
// R5 - software keeps input stable four sync periods
// R6 - link bit feeds comparator, clocked twice as fast
// R7 - clock select picks one of eight sync events
// R8 - amplified conversion starts only on sync event
// R9 - amplifier two has identical independent register
// R10 - one amplification per selected sync event
// R11 - registers read back written value, zero after reset
package acc_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] ACC_OFS_AMP_ONE = 4'h0;
  localparam logic [3:0] ACC_OFS_AMP_TWO = 4'h4;
  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  // field positions inside a control register
  localparam int ACC_BIT_EN = 7;
  localparam int ACC_BIT_SHORT = 6;
  localparam int ACC_BIT_GAIN_HI = 5;
  localparam int ACC_BIT_GAIN_LO = 4;
  localparam int ACC_BIT_LINK = 3;
  localparam int ACC_BIT_SEL_HI = 2;
  localparam int ACC_BIT_SEL_LO = 0;
  // sync event indices (clock select encoding)
  localparam int ACC_EV_ADC_DIV = 0;
  localparam int ACC_EV_T0_CMP = 1;
  localparam int ACC_EV_T0_OVF = 2;
  localparam int ACC_EV_T1_CMPB = 3;
  localparam int ACC_EV_T1_OVF = 4;
  localparam int ACC_EV_POWER_STAGE_SYNC_ZERO = 5;
  localparam int ACC_EV_POWER_STAGE_SYNC_ONE = 6;
  localparam int ACC_EV_POWER_STAGE_SYNC_TWO = 7;
  // last adc clock divider count; eight ticks per amplifier sync event
  localparam logic [2:0] ACC_ADC_DIV_LAST = 3'h7;
  // gain figures
  localparam logic [5:0] ACC_GAIN_5 = 6'h05;
  localparam logic [5:0] ACC_GAIN_10 = 6'h0A;
  localparam logic [5:0] ACC_GAIN_20 = 6'h14;
  localparam logic [5:0] ACC_GAIN_40 = 6'h28;
  // axi responses
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  // gain code to gain figure
  function automatic logic [5:0] acc_gain_of(input logic [1:0] code);
    case (code)
      2'h0: acc_gain_of = ACC_GAIN_5;
      2'h1: acc_gain_of = ACC_GAIN_10;
      2'h2: acc_gain_of = ACC_GAIN_20;
      default: acc_gain_of = ACC_GAIN_40;
    endcase
  endfunction
endpackage

// ### rtl/acc_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acc_chan_if;
  logic [7:0] cfg; // control register value
  logic [7:0] evt; // sync event pulses by select code
  logic conv_req; // conversion request from adc logic
  logic conv_busy; // conversion running
  logic amp_on; // effective amplifier enable
  logic in_short; // inputs shorted
  logic [1:0] gain_code; // gain field
  logic [5:0] gain_val; // gain figure
  logic cmp_link; // output routed to comparator
  logic amp_clk; // amplification pulse
  logic cmp_clk; // comparator clock pulse
  logic conv_go; // conversion start pulse
  modport ctl (output cfg, evt, conv_req, conv_busy,
    input amp_on, in_short, gain_code, gain_val, cmp_link, amp_clk, cmp_clk, conv_go);
  modport chn (input cfg, evt, conv_req, conv_busy,
    output amp_on, in_short, gain_code, gain_val, cmp_link, amp_clk, cmp_clk, conv_go);
endinterface
`default_nettype wire

// ### rtl/acc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module acc_chan
  import acc_pkg::*;
#(
  parameter int CNT_W = 8 // width of the sync period counter
)(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  acc_chan_if.chn ch // channel signals
);
  logic ev_sel; // selected sync event this cycle
  logic en_r, en_nxt; // effective enable
  logic pend_r, pend_nxt; // conversion request waiting for event
  logic [CNT_W-1:0] cnt_r, cnt_nxt; // cycles since last event
  logic [CNT_W-1:0] half_r, half_nxt; // half of last sync period
  logic short_r, link_r, amp_clk_r, cmp_clk_r, go_r; // output flops
  logic [1:0] gain_r; // gain code flop
  logic [5:0] gval_r; // gain figure flop

  // event chosen by the clock select field
  assign ev_sel = ch.evt[ch.cfg[ACC_BIT_SEL_HI:ACC_BIT_SEL_LO]]; // see R7

  // next state
  always_comb
  begin
    // turning off waits for the running conversion
    en_nxt = ch.cfg[ACC_BIT_EN] | (en_r & ch.conv_busy); // see R1
    // a request is held until a sync event lets it go
    pend_nxt = (pend_r | ch.conv_req) & en_r & ~(ev_sel & ~ch.conv_busy); // see R8
    // period measurement; saturates so a slow source cannot wrap
    if (ev_sel)
    begin
      cnt_nxt = '0;
      half_nxt = cnt_r >> 1;
    end
    else
    begin
      cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + 1'b1;
      half_nxt = half_r;
    end
  end

  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_r <= 1'b0;
      pend_r <= 1'b0;
      cnt_r <= '0;
      half_r <= '0;
      short_r <= 1'b0;
      link_r <= 1'b0;
      gain_r <= 2'h0;
      gval_r <= ACC_GAIN_5;
      amp_clk_r <= 1'b0;
      cmp_clk_r <= 1'b0;
      go_r <= 1'b0;
    end
    else if (ce)
    begin
      en_r <= en_nxt;
      pend_r <= pend_nxt;
      cnt_r <= cnt_nxt;
      half_r <= half_nxt;
      short_r <= ch.cfg[ACC_BIT_SHORT]; // see R3
      link_r <= ch.cfg[ACC_BIT_LINK]; // see R6
      gain_r <= ch.cfg[ACC_BIT_GAIN_HI:ACC_BIT_GAIN_LO];
      gval_r <= acc_gain_of(ch.cfg[ACC_BIT_GAIN_HI:ACC_BIT_GAIN_LO]); // see R4
      amp_clk_r <= en_r & ev_sel; // see R10
      // comparator gets a second pulse halfway through the period
      cmp_clk_r <= en_r & ch.cfg[ACC_BIT_LINK] &
        (ev_sel | (half_r != '0 && cnt_r == half_r)); // see R6
      go_r <= (pend_r | ch.conv_req) & en_r & ev_sel & ~ch.conv_busy; // see R8
    end
  end

  assign ch.amp_on = en_r;
  assign ch.in_short = short_r;
  assign ch.gain_code = gain_r;
  assign ch.gain_val = gval_r;
  assign ch.cmp_link = link_r;
  assign ch.amp_clk = amp_clk_r;
  assign ch.cmp_clk = cmp_clk_r;
  assign ch.conv_go = go_r;

  chk_off_waits: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
    ce && en_r && ch.conv_busy |=> en_r) else $error("amplifier dropped during conversion");
  chk_off_idle: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
    ce && !ch.cfg[ACC_BIT_EN] && !ch.conv_busy |=> !en_r) else $error("amplifier stayed on");
  chk_gain_map: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
    ce |=> gval_r == acc_gain_of($past(ch.cfg[5:4]))) else $error("gain figure wrong");
  chk_short_follow: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
    ce |=> short_r == $past(ch.cfg[6])) else $error("shunt not applied");
  chk_go_event: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
    go_r && $past(ce) |-> $past(ev_sel) && $past(en_r)) else $error("start without sync event");
  chk_amp_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
    ce && en_r && ev_sel |=> amp_clk_r) else $error("sync event missed");
  chk_cmp_gated: assert property (@(posedge aclk) disable iff (!aresetn) // see R6
    cmp_clk_r && $past(ce) |-> $past(ch.cfg[3])) else $error("comparator clocked unlinked");
endmodule
`default_nettype wire

// ### test/acc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: adc conversion logic and the sync event sources
module acc_far_model (
  input wire logic aclk, // system clock
  output logic [7:0] ev, // event pulses, index is the select code
  output logic [1:0] conv_req, // start request per channel
  output logic [1:0] conv_busy, // conversion running per channel
  input wire logic [1:0] amp_clk, // amplification pulses
  input wire logic [1:0] cmp_clk, // comparator clock pulses
  input wire logic [1:0] conv_go // conversion start pulses
);
  int n_amp[2]; // amplifications seen
  int n_cmp[2]; // comparator pulses seen
  int n_go[2]; // conversions started
  int bcnt[2]; // busy cycles left
  int blen = 30; // conversion length, long enough to overlap a bus write
  initial
  begin
    ev = 8'h00;
    conv_req = 2'h0;
    conv_busy = 2'h0;
  end
  // count pulses; each start runs one conversion of blen cycles
  always @(posedge aclk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      n_amp[c] += int'(amp_clk[c]);
      n_cmp[c] += int'(cmp_clk[c]);
      n_go[c] += int'(conv_go[c]);
      if (conv_go[c]) bcnt[c] = blen;
      else if (bcnt[c] > 0) bcnt[c]--;
      conv_busy[c] <= (bcnt[c] != 0);
    end
  end
  // one event pulse, then quiet so the result can land
  task automatic fire(input int k);
    @(posedge aclk);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // one conversion request pulse
  task automatic req(input int c);
    @(posedge aclk);
    conv_req[c] <= 1'b1;
    @(posedge aclk);
    conv_req[c] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb_amplifier_channel_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_amplifier_channel_control;
  import acc_pkg::*;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, wstrb, araddr, gain_code;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, conv_req, conv_busy, amp_on, in_short, cmp_link;
  logic [1:0] amp_clk, cmp_clk, conv_go, gg;
  logic [11:0] gain_val;
  logic [7:0] ev, d;
  int n_mismatch, compares, seed, regm[2], a0, a1;
  acc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .adc_clk_tick(ev[0]),
    .t0_cmp(ev[1]), .t0_ovf(ev[2]), .t1_cmpb(ev[3]), .t1_ovf(ev[4]),
    .power_stage_sync_zero(ev[5]), .power_stage_sync_one(ev[6]),
    .power_stage_sync_two(ev[7]), .conv_req(conv_req), .conv_busy(conv_busy),
    .amp_on(amp_on), .in_short(in_short), .gain_code(gain_code), .gain_val(gain_val),
    .cmp_link(cmp_link), .amp_clk(amp_clk), .cmp_clk(cmp_clk), .conv_go(conv_go));
  acc_far_model far_u (.aclk(aclk), .ev(ev), .conv_req(conv_req), .conv_busy(conv_busy),
    .amp_clk(amp_clk), .cmp_clk(cmp_clk), .conv_go(conv_go));
  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // gain figure doubles per code step
  function automatic logic [5:0] gfig(input logic [1:0] c);
    return 6'(5 << c);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // bus write; both halves offered together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'($random(seed)), v};
    wstrb <= s;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check("write resp", bresp, (a[3] || a[1:0] != 0) ? ACC_RESP_SLVERR : ACC_RESP_OKAY);
    if (!a[3] && a[1:0] == 0 && s[0]) regm[a[2]] = v;
  endtask
  // bus read compared with the register model
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    check("read data", rdata, a[3] ? 0 : regm[a[2]]);
    check("read resp", rresp, a[3] ? ACC_RESP_SLVERR : ACC_RESP_OKAY);
  endtask
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, far beyond the fewer than a thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    seed = 35769;
    ce = 1'b1;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("reset amp_on", amp_on, 2'h0);
    check("reset gain", gain_val, {ACC_GAIN_5, ACC_GAIN_5});
    axr(4'h0);
    axr(4'h4);
    axr(4'h8);
    // random readback, ignored byte strobe, unmapped place
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      axw({1'b0, i[0], 2'h0}, d, 4'hF);
      axw({1'b0, i[0], 2'h0}, ~d, 4'h0);
      axw(4'h8, d, 4'hF);
      axr({1'b0, i[0], 2'h0});
    end
    // static fields, channels set to opposite values
    for (int i = 0; i < 4; i++)
    begin
      gg = 2'(i);
      axw(4'h0, {1'b1, gg[0], gg, gg[1], 3'h1}, 4'hF);
      axw(4'h4, {1'b1, ~gg[0], ~gg, ~gg[1], 3'h2}, 4'hF);
      repeat (2) @(posedge aclk);
      check("amp_on", amp_on, 2'h3);
      check("shunt", in_short, {~gg[0], gg[0]});
      check("gain code", gain_code, {~gg, gg});
      check("gain", gain_val, {gfig(~gg), gfig(gg)});
      check("link", cmp_link, {~gg[1], gg[1]});
    end
    // each select code on one channel, its mirror on the other
    for (int s = 0; s < 8; s++)
    begin
      axw(4'h0, 8'h80 | 8'(s), 4'hF);
      axw(4'h4, 8'h80 | 8'(7 - s), 4'hF);
      a0 = far_u.n_amp[0];
      a1 = far_u.n_amp[1];
      for (int k = 1; k < 8; k++) far_u.fire(k);
      check("amp pulses ch0", far_u.n_amp[0] - a0, s != 0);
      check("amp pulses ch1", far_u.n_amp[1] - a1, s != 7);
    end
    // adc clock divided by eight; channel two is left on select 0, one on 7
    a0 = far_u.n_amp[0];
    a1 = far_u.n_amp[1];
    repeat (16) far_u.fire(0);
    check("div8 pulses", far_u.n_amp[1] - a1, 2);
    check("div8 other select", far_u.n_amp[0] - a0, 0);
    // comparator clock at twice the rate when linked
    axw(4'h0, 8'h81, 4'hF);
    axw(4'h4, 8'h89, 4'hF);
    repeat (4)
    begin
      far_u.fire(1);
      repeat (15) @(posedge aclk);
    end
    a0 = far_u.n_cmp[0];
    a1 = far_u.n_cmp[1];
    repeat (2)
    begin
      far_u.fire(1);
      repeat (15) @(posedge aclk);
    end
    check("cmp pulses ch0", far_u.n_cmp[0] - a0, 0);
    check("cmp pulses ch1", far_u.n_cmp[1] - a1, 4);
    // start waits for the sync event; disable waits for the conversion
    a0 = far_u.n_go[0];
    far_u.req(0);
    repeat (6) @(posedge aclk);
    check("early start", far_u.n_go[0] - a0, 0);
    far_u.fire(1);
    check("start", far_u.n_go[0] - a0, 1);
    axw(4'h0, 8'h00, 4'hF);
    repeat (2) @(posedge aclk);
    check("busy hold", amp_on, 2'h3);
    repeat (40) @(posedge aclk);
    check("off", amp_on, 2'h2);
    // clock enable low: a sync event must leave every flop alone
    a1 = far_u.n_amp[1];
    ce <= 1'b0;
    far_u.fire(1);
    ce <= 1'b1;
    check("frozen pulses", far_u.n_amp[1] - a1, 0);
    check("frozen enable", amp_on, 2'h2);
    // reset in mid-run must clear both registers again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    regm[0] = 0;
    regm[1] = 0;
    @(posedge aclk);
    check("reset again", amp_on, 2'h0);
    axr(4'h0);
    axr(4'h4);
    complete_run();
  end
endmodule
`default_nettype wire
